// ### rtl/css_startup_sequencer.sv
// module: startup sequencing, handshake and pin roles of the combo module
`timescale 1ns/10ps
// Overview of operation
// - in 4-bit mode all four data lines carry data with line 1 also the interrupt, in 1-bit mode line 0 is the data, line 1 the interrupt and lines 2 and 3 unused.
// - the sleep clock input is the time base of all boot and low-power counting.
// - after the wlan enable rises the module waits a programmed 1 to 255 sleep clock periods before continuing boot.
// - after reset the radio section lets its reference clock settle and then settles its pins before the handshake.
// - once initialised the radio drives its request-to-send low after the host drives clear-to-send low.
// - each radio wake pin serves either as a wake signal or as a general-purpose pin.
// - while the wlan enable is low its regulators stay off and the section stays in reset.
module css_startup_sequencer
  import css_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       sleep_clock_in,
  input  wire logic       wlan_section_enable,
  input  wire logic       radio_section_enable,
  input  wire logic [7:0] boot_wait_periods,
  input  wire logic       radio_uart_clear_to_send_n,
  input  wire logic       sd_four_bit_mode,
  input  wire logic       sd_irq_request,
  input  wire logic [3:0] sd_data_out,
  input  wire logic [3:0] sd_data_oe,
  input  wire logic [3:0] sd_data_pin_in,
  input  wire logic       radio_wake_to_host_gpio_mode,
  input  wire logic       radio_wake_to_host_gpio_out,
  input  wire logic       radio_wake_to_host_gpio_oe,
  input  wire logic       radio_wake_to_host_event,
  input  wire logic       radio_wake_from_host_gpio_mode,
  input  wire logic       radio_wake_from_host_gpio_out,
  input  wire logic       radio_wake_from_host_gpio_oe,
  input  wire logic       radio_wake_from_host_in,
  output logic            wlan_regulators_on,
  output logic            wlan_reset_n,
  output logic            wlan_boot_go,
  output logic            radio_reset_n,
  output logic            radio_ready,
  output logic            radio_uart_req_to_send_n,
  output logic [3:0]      sd_data_pin_out,
  output logic [3:0]      sd_data_pin_oe,
  output logic [3:0]      sd_data_rx,
  output logic            radio_wake_to_host_out,
  output logic            radio_wake_to_host_oe,
  output logic            radio_wake_from_host_out,
  output logic            radio_wake_from_host_oe,
  output logic            radio_wake_req,
  output logic            radio_wake_from_host_gpio_in
);

  localparam int unsigned NSYNC = 5;

  // the sleep clock is sampled, so the system clock must be well above it
  if (CLK_HZ < 4 * SLEEP_CLK_HZ)
  begin : g_clk_too_slow
    $error("system clock too slow to sample the sleep clock");
  end

  // the sleep clock, enable, cts and wake pins from the host are synchronised (sd data pins are not); stage 1 is read only by stage 2
  logic [NSYNC-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic             lpo_prev_reg, lpo_prev_next;
  logic             lpo, wl_en, rd_en, cts_n, wake_in;

  always_comb
  begin
    sync1_next    = {radio_wake_from_host_in, radio_uart_clear_to_send_n, radio_section_enable,
                     wlan_section_enable, sleep_clock_in};
    sync2_next    = sync1_reg;
    lpo_prev_next = sync2_reg[0];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      lpo_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg    <= sync1_next;
      sync2_reg    <= sync2_next;
      lpo_prev_reg <= lpo_prev_next;
    end
  end

  assign lpo     = sync2_reg[0] & ~lpo_prev_reg;
  assign wl_en   = sync2_reg[1];
  assign rd_en   = sync2_reg[2];
  assign cts_n   = sync2_reg[3];
  assign wake_in = sync2_reg[4];

  // wlan section power and boot wait, counted in sleep clock periods
  css_wl_state_e wl_state_reg, wl_state_next;
  logic [7:0]    wl_cnt_reg, wl_cnt_next;
  logic [7:0]    wait_target;

  // zero is not a legal wait; treat it as the shortest one
  assign wait_target = (boot_wait_periods < BOOT_WAIT_MIN) ? BOOT_WAIT_MIN : boot_wait_periods;

  always_comb
  begin
    wl_state_next = wl_state_reg;
    wl_cnt_next   = wl_cnt_reg;
    if (!wl_en)
    begin
      wl_state_next = CSS_WL_OFF;
      wl_cnt_next   = COUNT_RESET;
    end
    else
    begin
      unique case (wl_state_reg)
        CSS_WL_OFF:
        begin
          wl_state_next = CSS_WL_WAIT;
          wl_cnt_next   = COUNT_RESET;
        end
        CSS_WL_WAIT:
        begin
          if (lpo)
          begin
            wl_cnt_next = wl_cnt_reg + 8'h0_001;
            if (wl_cnt_reg + 8'h0_001 >= wait_target)
              wl_state_next = CSS_WL_BOOT;
          end
        end
        CSS_WL_BOOT:
        begin
          wl_state_next = CSS_WL_BOOT;
        end
        // unused code: fall back to off rather than hang
        default:
        begin
          wl_state_next = CSS_WL_OFF;
          wl_cnt_next   = COUNT_RESET;
        end
      endcase
    end
  end

  // radio section: reference settle, pin settle, then flow-control handshake
  css_rd_state_e rd_state_reg, rd_state_next;
  logic [7:0]    rd_cnt_reg, rd_cnt_next;
  logic          rts_n_reg, rts_n_next;

  always_comb
  begin
    rd_state_next = rd_state_reg;
    rd_cnt_next   = rd_cnt_reg;
    rts_n_next    = 1'b1;
    if (!rd_en)
    begin
      rd_state_next = CSS_RD_OFF;
      rd_cnt_next   = COUNT_RESET;
    end
    else
    begin
      unique case (rd_state_reg)
        CSS_RD_OFF:
        begin
          rd_state_next = CSS_RD_REF;
          rd_cnt_next   = COUNT_RESET;
        end
        CSS_RD_REF:
        begin
          if (lpo)
            rd_cnt_next = rd_cnt_reg + 8'h0_001;
          if (lpo && (rd_cnt_reg + 8'h0_001 >= REF_SETTLE_EDGES))
          begin
            rd_state_next = CSS_RD_IO;
            rd_cnt_next   = COUNT_RESET;
          end
        end
        CSS_RD_IO:
        begin
          if (lpo)
            rd_cnt_next = rd_cnt_reg + 8'h0_001;
          if (lpo && (rd_cnt_reg + 8'h0_001 >= IO_SETTLE_EDGES))
            rd_state_next = CSS_RD_WAIT_CTS;
        end
        CSS_RD_WAIT_CTS:
        begin
          if (!cts_n)
          begin
            rd_state_next = CSS_RD_READY;
            rts_n_next    = 1'b0;
          end
        end
        CSS_RD_READY:
        begin
          rts_n_next = 1'b0;
        end
        default:
        begin
          rd_state_next = CSS_RD_OFF;
          rd_cnt_next   = COUNT_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wl_state_reg <= CSS_WL_OFF;
      wl_cnt_reg   <= COUNT_RESET;
      rd_state_reg <= CSS_RD_OFF;
      rd_cnt_reg   <= COUNT_RESET;
      rts_n_reg    <= 1'b1;
    end
    else
    begin
      wl_state_reg <= wl_state_next;
      wl_cnt_reg   <= wl_cnt_next;
      rd_state_reg <= rd_state_next;
      rd_cnt_reg   <= rd_cnt_next;
      rts_n_reg    <= rts_n_next;
    end
  end

  assign wlan_regulators_on       = (wl_state_reg != CSS_WL_OFF);
  assign wlan_reset_n             = (wl_state_reg == CSS_WL_BOOT);
  assign wlan_boot_go             = (wl_state_reg == CSS_WL_BOOT);
  assign radio_reset_n            = (rd_state_reg != CSS_RD_OFF);
  assign radio_ready              = (rd_state_reg == CSS_RD_READY);
  assign radio_uart_req_to_send_n = rts_n_reg;

  // sd data pin roles; line 1 carries the interrupt in both modes, low active
  always_comb
  begin
    sd_data_pin_out = sd_data_out;
    sd_data_pin_oe  = sd_data_oe;
    sd_data_rx      = sd_data_pin_in;
    if (!sd_four_bit_mode)
    begin
      sd_data_pin_out = {2'b00, 1'b0, sd_data_out[0]};
      sd_data_pin_oe  = {2'b00, sd_irq_request, sd_data_oe[0]};
      sd_data_rx      = {3'b000, sd_data_pin_in[0]};
    end
    else if (sd_irq_request && !sd_data_oe[1])
    begin
      sd_data_pin_out[1] = 1'b0;
      sd_data_pin_oe[1]  = 1'b1;
    end
  end

  // wake pins: wake role or general-purpose role
  assign radio_wake_to_host_out   = radio_wake_to_host_gpio_mode ? radio_wake_to_host_gpio_out
                                                                 : radio_wake_to_host_event;
  assign radio_wake_to_host_oe    = radio_wake_to_host_gpio_mode ? radio_wake_to_host_gpio_oe
                                                                 : radio_reset_n;
  assign radio_wake_from_host_out = radio_wake_from_host_gpio_out;
  assign radio_wake_from_host_oe  = radio_wake_from_host_gpio_mode & radio_wake_from_host_gpio_oe;
  assign radio_wake_req           = ~radio_wake_from_host_gpio_mode & wake_in;
  assign radio_wake_from_host_gpio_in = wake_in;

endmodule

// ### rtl/css_pkg.sv
// package: constants and state types of the combo module startup sequencer
package css_pkg;
  localparam int unsigned SLEEP_CLK_HZ      = 32768;
  localparam int unsigned CLK_HZ            = 125000000;
  // sleep clock edges the radio needs for its reference clock to settle
  localparam logic [7:0]  REF_SETTLE_EDGES  = 8'h0_004;
  // sleep clock edges the radio needs to settle its own pins
  localparam logic [7:0]  IO_SETTLE_EDGES   = 8'h0_002;
  localparam logic [7:0]  BOOT_WAIT_MIN     = 8'h0_001;
  localparam logic [7:0]  BOOT_WAIT_RESET   = 8'h0_001;
  localparam logic [7:0]  COUNT_RESET       = 8'h0_000;

  typedef enum logic [1:0] {
    CSS_WL_OFF,
    CSS_WL_WAIT,
    CSS_WL_BOOT
  } css_wl_state_e;

  typedef enum logic [2:0] {
    CSS_RD_OFF,
    CSS_RD_REF,
    CSS_RD_IO,
    CSS_RD_WAIT_CTS,
    CSS_RD_READY
  } css_rd_state_e;
endpackage

// ### tb/css_seq_props.sv
// checker: timing and pin-role properties of the startup sequencer
`timescale 1ns/10ps
module css_seq_props (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       wlan_section_enable,
  input wire logic       wlan_regulators_on,
  input wire logic       wlan_reset_n,
  input wire logic       wlan_boot_go,
  input wire logic       radio_reset_n,
  input wire logic       radio_ready,
  input wire logic       radio_uart_req_to_send_n,
  input wire logic       radio_uart_clear_to_send_n,
  input wire logic       sd_four_bit_mode,
  input wire logic       sd_irq_request,
  input wire logic [3:0] sd_data_oe,
  input wire logic [3:0] sd_data_rx,
  input wire logic [3:0] sd_data_pin_oe,
  input wire logic [3:0] sd_data_pin_out,
  input wire logic       radio_wake_from_host_gpio_mode,
  input wire logic       radio_wake_from_host_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_wl_off; !wlan_section_enable [*6] |-> !wlan_regulators_on && !wlan_reset_n; endproperty
  a_wl_off: assert property (p_wl_off) else $error("wlan alive while disabled");
  property p_wl_on; $rose(wlan_section_enable) |-> ##[2:6] wlan_regulators_on; endproperty
  a_wl_on: assert property (p_wl_on) else $error("wlan regulators late");
  property p_boot; $rose(wlan_reset_n) |-> $past(wlan_regulators_on) && wlan_boot_go; endproperty
  a_boot: assert property (p_boot) else $error("boot released early");
  property p_rts; $fell(radio_uart_req_to_send_n) |-> !$past(radio_uart_clear_to_send_n, 3); endproperty
  a_rts: assert property (p_rts) else $error("rts fell without cts");
  // reference and pin settling take six sleep edges, far more than eight clocks
  property p_rseq; $fell(radio_uart_req_to_send_n) |-> $past(radio_reset_n, 8) && radio_ready; endproperty
  a_rseq: assert property (p_rseq) else $error("rts before radio settled");
  property p_rx1; !sd_four_bit_mode |-> sd_data_rx[3:1] == 3'h0 && sd_data_pin_oe[3:2] == 2'h0; endproperty
  a_rx1: assert property (p_rx1) else $error("unused data lines active");
  property p_irq; !sd_four_bit_mode && sd_irq_request |-> sd_data_pin_oe[1] && !sd_data_pin_out[1]; endproperty
  a_irq: assert property (p_irq) else $error("irq not on data line 1");
  property p_irq4; sd_four_bit_mode && sd_irq_request |-> sd_data_pin_oe[1] && (sd_data_oe[1] || !sd_data_pin_out[1]); endproperty
  a_irq4: assert property (p_irq4) else $error("irq not driven in 4-bit mode");
  property p_dw; !radio_wake_from_host_gpio_mode |-> !radio_wake_from_host_oe; endproperty
  a_dw: assert property (p_dw) else $error("wake input driven");
  c_boot: cover property ($rose(wlan_reset_n));
  c_ready: cover property ($rose(radio_ready));
  c_irq: cover property (!sd_four_bit_mode && sd_irq_request);
endmodule
bind css_startup_sequencer css_seq_props u_props (.*);

// ### tb/css_host_model.sv
// partner: host that makes the sleep clock and drives enables and cts
`timescale 1ns/10ps
module css_host_model #(parameter int HALF = 8) (
  input wire logic clk,
  output logic     sleep_clock_in,
  output logic     wlan_section_enable,
  output logic     radio_section_enable,
  output logic     radio_uart_clear_to_send_n
);
  int cnt = 0;
  initial
  begin
    sleep_clock_in = 1'b0;
    wlan_section_enable = 1'b0;
    radio_section_enable = 1'b0;
    radio_uart_clear_to_send_n = 1'b1;
  end
  // sleep clock runs free, scaled down so waits stay short
  always @(posedge clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      sleep_clock_in <= !sleep_clock_in;
  end
  // pins are settled from time zero, so enables only wait two sleep periods
  task automatic set_en(input bit wl, input bit rd);
    repeat (2) @(posedge sleep_clock_in);
    @(posedge clk);
    wlan_section_enable <= wl;
    radio_section_enable <= rd;
  endtask
  task automatic set_cts(input bit v);
    @(posedge clk);
    radio_uart_clear_to_send_n <= v;
  endtask
endmodule

// ### tb/tb.sv
// testbench: startup sequencing, handshake and pin roles
`timescale 1ns/10ps
module tb;
  import css_pkg::*;
  localparam int P = 16;
  logic clk = 1'b0, rstn = 1'b0, host_oe = 1'b0;
  logic sleep_clock_in, wlan_section_enable, radio_section_enable, radio_uart_clear_to_send_n;
  logic [7:0] boot_wait_periods = 8'h01;
  logic sd_four_bit_mode = 1'b1, sd_irq_request = 1'b0;
  logic [3:0] sd_data_out = 4'h0, sd_data_oe = 4'h0, host_d = 4'h0, sd_data_pin_in;
  logic radio_wake_to_host_gpio_mode = 1'b0, radio_wake_to_host_gpio_out = 1'b0;
  logic radio_wake_to_host_gpio_oe = 1'b0, radio_wake_to_host_event = 1'b1;
  logic radio_wake_from_host_gpio_mode = 1'b0, radio_wake_from_host_gpio_out = 1'b0;
  logic radio_wake_from_host_gpio_oe = 1'b0, radio_wake_from_host_in = 1'b0;
  logic wlan_regulators_on, wlan_reset_n, wlan_boot_go, radio_reset_n, radio_ready;
  logic radio_uart_req_to_send_n, radio_wake_req, radio_wake_from_host_gpio_in;
  logic [3:0] sd_data_pin_out, sd_data_pin_oe, sd_data_rx;
  logic radio_wake_to_host_out, radio_wake_to_host_oe, radio_wake_from_host_out, radio_wake_from_host_oe;
  int mismatches = 0, compares = 0, cyc = 0;
  // undriven lines float to the pull-up level
  assign sd_data_pin_in = (sd_data_pin_oe & sd_data_pin_out) | (~sd_data_pin_oe & (host_oe ? host_d : 4'hf));
  css_startup_sequencer dut (.*);
  css_host_model #(.HALF(P / 2)) host (.*);
  always #4 clk = ~clk;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_wlan(input logic [7:0] n);
    int c = 0;
    int e = (n == 0) ? 1 : n;
    @(posedge clk);
    boot_wait_periods <= n;
    host.set_en(1'b1, 1'b0);
    while (wlan_regulators_on !== 1'b1) @(negedge clk);
    while (wlan_reset_n !== 1'b1)
    begin
      @(negedge clk);
      c++;
    end
    check("wlan wait", 32'(c >= (e - 1) * P && c <= e * P + 4), 1);
    check("boot go", wlan_boot_go, 1);
    host.set_en(1'b0, 1'b0);
    repeat (6) @(negedge clk);
    check("wlan off", {wlan_regulators_on, wlan_reset_n}, 0);
    $display("wlan test done, wait %0d", n);
  endtask
  task automatic t_radio(input bit early);
    int c = 0;
    int e = REF_SETTLE_EDGES + IO_SETTLE_EDGES;
    host.set_en(1'b0, 1'b1);
    if (early)
      host.set_cts(1'b0);
    while (radio_reset_n !== 1'b1) @(negedge clk);
    if (!early)
    begin
      // settled but no cts yet: rts must stay high
      repeat (e * P + 8) @(negedge clk);
      check("rts held", {radio_ready, radio_uart_req_to_send_n}, 1);
      host.set_cts(1'b0);
    end
    while (radio_uart_req_to_send_n !== 1'b0)
    begin
      @(negedge clk);
      c++;
    end
    if (early)
      check("rts delay", 32'(c >= (e - 1) * P && c <= e * P + 8), 1);
    else
      check("cts to rts", 32'(c >= 2 && c <= 4), 1);
    check("ready", radio_ready, 1);
    check("host wake", {radio_wake_to_host_oe, radio_wake_to_host_out}, 3);
    host.set_en(1'b0, 1'b0);
    host.set_cts(1'b1);
    repeat (6) @(negedge clk);
    check("radio off", {radio_reset_n, radio_uart_req_to_send_n}, 1);
    $display("radio test done");
  endtask
  task automatic t_sd;
    @(posedge clk);
    host_oe <= 1'b1;
    host_d <= 4'h5;
    @(negedge clk);
    check("rx 4bit", sd_data_rx, 4'h5);
    @(posedge clk);
    sd_irq_request <= 1'b1;
    sd_data_out <= 4'ha;
    sd_data_oe <= 4'h9;
    @(negedge clk);
    check("irq 4bit", {sd_data_pin_oe, sd_data_pin_out}, 8'hb8);
    @(posedge clk);
    sd_data_oe <= 4'hf;
    @(negedge clk);
    check("data 4bit", {sd_data_pin_oe, sd_data_pin_out}, 8'hfa);
    @(posedge clk);
    sd_four_bit_mode <= 1'b0;
    sd_irq_request <= 1'b1;
    sd_data_oe <= 4'hc;
    @(negedge clk);
    check("rx 1bit", sd_data_rx, 4'h1);
    check("pins 1bit", {sd_data_pin_oe, sd_data_pin_out[1]}, 5'h04);
    $display("sd test done");
  endtask
  task automatic t_wake;
    @(posedge clk);
    radio_wake_to_host_gpio_mode <= 1'b1;
    radio_wake_to_host_gpio_oe <= 1'b1;
    radio_wake_from_host_gpio_mode <= 1'b1;
    radio_wake_from_host_gpio_oe <= 1'b1;
    radio_wake_from_host_gpio_out <= 1'b1;
    radio_wake_from_host_in <= 1'b1;
    repeat (4) @(negedge clk);
    check("gpio roles", {radio_wake_to_host_oe, radio_wake_to_host_out, radio_wake_from_host_oe,
                         radio_wake_from_host_out, radio_wake_req, radio_wake_from_host_gpio_in}, 6'h2d);
    @(posedge clk);
    radio_wake_from_host_gpio_mode <= 1'b0;
    repeat (4) @(negedge clk);
    check("wake role", {radio_wake_from_host_oe, radio_wake_req}, 1);
    $display("wake test done");
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_wlan(8'h03);
    t_wlan(8'h00);
    t_radio(1'b0);
    t_radio(1'b1);
    t_sd();
    t_wake();
    finish_test();
  end
endmodule
